// ### design/guard_pkg.sv
// Shared constants and types of the sink driver protection logic
package guard_pkg;

	// Register byte offsets on the APB bus
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
	localparam logic [ADDR_W-1:0] REG_INT_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] REG_INT_MASK = 8'h08;

	// Event bits, shared by sticky status and mask
	localparam int EV_TSD = 0;
	localparam int EV_UVLO = 1;
	localparam int EV_OC_A = 2;
	localparam int EV_OC_B = 3;
	localparam int EV_W = 4;
	localparam logic [EV_W-1:0] INT_MASK_RST = 4'h0;
	localparam logic [EV_W-1:0] INT_STAT_RST = 4'h0;

	// Live status word fields
	localparam int ST_TSD = 0;
	localparam int ST_UVLO = 1;
	localparam int ST_OC = 2;
	localparam int ST_SINK_A = 3;
	localparam int ST_SINK_B = 4;
	localparam int ST_IN_A = 5;
	localparam int ST_IN_B = 6;
	localparam int ST_W = 7;

	// Positions of the pins in the synchroniser vector
	localparam int PIN_IN_A = 0;
	localparam int PIN_IN_B = 1;
	localparam int PIN_THERM = 2;
	localparam int PIN_OC_A = 3;
	localparam int PIN_OC_B = 4;
	localparam int PIN_LOW = 5;
	localparam int PIN_OK = 6;
	localparam int PIN_W = 7;

	// Reset state of the protection logic
	localparam logic UVLO_RST = 1'b1;
	localparam logic TSD_RST = 1'b0;

	// Timing, in printed units and in cycles of pclk
	localparam int CLK_PERIOD_NS = 100;
	localparam int TSD_MASK_NS = 5000;
	localparam int TSD_MASK_CYC = (TSD_MASK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_BLANK_NS = 1250;
	localparam int OC_BLANK_CYC = (OC_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OC_OFF_MS = 3;
	localparam int OC_OFF_CYC = (OC_OFF_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IN_MIN_PULSE_NS = 500;

	// Overcurrent recovery states
	typedef enum logic [0:0] {OC_RUN, OC_HOLD} oc_st_e;

endpackage

// ### design/timer_if.sv
// Start and expiry handshake between the guard and one of its timers
interface timer_if;
	logic run;
	logic done;
	modport owner (output run, input done);
	modport counter (input run, output done);
endinterface

// ### design/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
module pin_sync #(
	parameter int W = 7
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] pin,
	output logic [W-1:0] filt
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} sync_s;

	sync_s st_r;
	sync_s st_nxt;

	// Shift the pins in; a bit moves only when stages two and three agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.q = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.q & (st_r.s2 ^ st_r.s3));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign filt = st_r.q;

endmodule

// ### design/hold_timer.sv
// Persistence timer: done once run has stood for LIMIT cycles
module hold_timer #(
	parameter int unsigned LIMIT = 50
) (
	input wire logic pclk,
	input wire logic presetn,
	timer_if.counter t
);

	localparam int W = $clog2(LIMIT + 1);
	localparam logic [W-1:0] LIM = W'(LIMIT);

	typedef struct packed {
		logic [W-1:0] cnt;
		logic done;
	} tmr_s;

	tmr_s st_r;
	tmr_s st_nxt;

	// Count while run holds, saturate at the limit, restart when run drops
	always_comb begin
		st_nxt = st_r;
		if (!t.run) begin
			st_nxt.cnt = '0;
		end else if (st_r.cnt != LIM) begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
		st_nxt.done = t.run && (st_nxt.cnt == LIM);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign t.done = st_r.done;

endmodule

// ### design/sink_guard.sv
// Control and protection logic of a two-channel low-side sink driver
// What this block does
// - Each sink switch is on while its own control input is high, the two independently.
// - In normal operation the fault flag pull-down stays off so the pin floats high.
// - While thermal shutdown is active the fault flag pull-down is on.
// - When thermal shutdown clears the fault flag pull-down is released.
// - An accepted over-temperature trip forces both sink switches off.
// - The over-temperature trip is masked so a short switching glitch is ignored.
// - After thermal shutdown the outputs resume on their own once the trip drops.
// - A supply undervoltage indication forces both sink switches off.
// - The undervoltage lockout clears only when the supply-good indication returns.
// - An accepted overcurrent trip turns the sink switches off.
// - The overcurrent detector is ignored during a blanking window.
// - After an overcurrent shutdown the outputs recover after a fixed off time.
// - The overcurrent blanking window is 1.25 us.
// - The overcurrent off time is 3 ms.
// - Over-temperature must persist 2.0 to 8.0 us, nominally 5.0, before shutdown.
//
// The implementer's own choices: the address map and the APB slave port.
module sink_guard
	import guard_pkg::*;
#(
	parameter int unsigned TSD_MASK_CYCLES = TSD_MASK_CYC,
	parameter int unsigned OC_BLANK_CYCLES = OC_BLANK_CYC,
	parameter int unsigned OC_OFF_CYCLES = OC_OFF_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ctrl_in_a,
	input wire logic ctrl_in_b,
	input wire logic thermal_trip,
	input wire logic overcurrent_trip_a,
	input wire logic overcurrent_trip_b,
	input wire logic motor_supply_low,
	input wire logic motor_supply_ok,
	output logic sink_out_a,
	output logic sink_out_b,
	output logic fault_flag_o,
	output logic fault_flag_oe,
	output logic irq
);

	localparam int CNT_W = 16; // Run-length counters used by the checks

	typedef struct packed {
		logic [1:0] sink;
		logic flag_o;
		logic flag_oe;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic thermal_sd;
		logic uvlo;
		oc_st_e oc_st;
		logic [EV_W-1:0] int_stat;
		logic [EV_W-1:0] int_mask;
		logic [CNT_W-1:0] therm_cnt;
		logic [CNT_W-1:0] blk_cnt;
	} guard_s;

	guard_s st_r;
	guard_s st_nxt;

	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_f;
	logic in_a_f;
	logic in_b_f;
	logic therm_f;
	logic low_f;
	logic ok_f;
	logic [1:0] oc_f;
	logic [1:0] trip;
	logic blocked;
	logic setup;
	logic acc;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] clr;
	logic [ST_W-1:0] status;

	timer_if tsd_t();
	timer_if off_t();
	timer_if blk_t[2]();

	// True for any offset that holds a register
	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		return (a == REG_STATUS) || (a == REG_INT_STAT) || (a == REG_INT_MASK);
	endfunction

	// Saturating run length of a level, restarts when it drops
	function automatic logic [CNT_W-1:0] run_len(input logic run, input logic [CNT_W-1:0] c);
		return run ? ((c == '1) ? c : c + 1'b1) : '0;
	endfunction

	// Read multiplexer; unmapped offsets read zero
	function automatic logic [31:0] read_word(
		input logic [ADDR_W-1:0] a,
		input logic [ST_W-1:0] st,
		input logic [EV_W-1:0] ist,
		input logic [EV_W-1:0] msk
	);
		logic [31:0] w;
		w = 32'h0;
		case (a)
			REG_STATUS: w[ST_W-1:0] = st;
			REG_INT_STAT: w[EV_W-1:0] = ist;
			REG_INT_MASK: w[EV_W-1:0] = msk;
			default: w = 32'h0;
		endcase
		return w;
	endfunction

	// All pins come from outside pclk; short host pulses are not stretched
	assign pin_raw[PIN_IN_A] = ctrl_in_a;
	assign pin_raw[PIN_IN_B] = ctrl_in_b;
	assign pin_raw[PIN_THERM] = thermal_trip;
	assign pin_raw[PIN_OC_A] = overcurrent_trip_a;
	assign pin_raw[PIN_OC_B] = overcurrent_trip_b;
	assign pin_raw[PIN_LOW] = motor_supply_low;
	assign pin_raw[PIN_OK] = motor_supply_ok;

	pin_sync #(
		.W(PIN_W)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin(pin_raw),
		.filt(pin_f)
	);

	assign in_a_f = pin_f[PIN_IN_A];
	assign in_b_f = pin_f[PIN_IN_B];
	assign therm_f = pin_f[PIN_THERM];
	assign oc_f = {pin_f[PIN_OC_B], pin_f[PIN_OC_A]};
	assign low_f = pin_f[PIN_LOW];
	assign ok_f = pin_f[PIN_OK];

	// Thermal mask: the trip must persist before shutdown is taken
	assign tsd_t.run = therm_f;

	hold_timer #(
		.LIMIT(TSD_MASK_CYCLES)
	) u_tsd_mask (
		.pclk(pclk),
		.presetn(presetn),
		.t(tsd_t)
	);

	// Overcurrent blanking, one per channel, armed only while it conducts
	generate
		for (genvar i = 0; i < 2; i++) begin : g_blank
			assign blk_t[i].run = oc_f[i] & st_r.sink[i];
			assign trip[i] = blk_t[i].done;

			hold_timer #(
				.LIMIT(OC_BLANK_CYCLES)
			) u_blank (
				.pclk(pclk),
				.presetn(presetn),
				.t(blk_t[i])
			);
		end
	endgenerate

	// Off time after an accepted overcurrent trip
	assign off_t.run = (st_r.oc_st == OC_HOLD);

	hold_timer #(
		.LIMIT(OC_OFF_CYCLES)
	) u_oc_off (
		.pclk(pclk),
		.presetn(presetn),
		.t(off_t)
	);

	// Protection state, output gating, interrupts and APB slave
	always_comb begin
		st_nxt = st_r;
		setup = psel & ~penable;
		acc = psel & penable & st_r.pready;
		st_nxt.therm_cnt = run_len(therm_f, st_r.therm_cnt);
		st_nxt.blk_cnt = run_len(blk_t[0].run, st_r.blk_cnt);

		// Thermal shutdown: set on masked trip, clears with the raw trip
		if (tsd_t.done && therm_f) begin
			st_nxt.thermal_sd = 1'b1;
		end else if (!therm_f) begin
			st_nxt.thermal_sd = 1'b0;
		end

		// Undervoltage lockout with separate trip and release levels
		if (low_f) begin
			st_nxt.uvlo = 1'b1;
		end else if (ok_f) begin
			st_nxt.uvlo = 1'b0;
		end

		// Overcurrent hold and automatic recovery
		case (st_r.oc_st)
			OC_RUN: begin
				if (|trip) begin
					st_nxt.oc_st = OC_HOLD;
				end
			end
			OC_HOLD: begin
				if (off_t.done) begin
					st_nxt.oc_st = OC_RUN;
				end
			end
			default: begin
				st_nxt.oc_st = OC_RUN;
			end
		endcase

		// Any active protection overrides both control inputs
		blocked = st_nxt.thermal_sd | st_nxt.uvlo | (st_nxt.oc_st == OC_HOLD);
		st_nxt.sink[0] = in_a_f & ~blocked;
		st_nxt.sink[1] = in_b_f & ~blocked;

		// Open-drain flag follows thermal shutdown alone
		st_nxt.flag_o = 1'b0;
		st_nxt.flag_oe = st_nxt.thermal_sd;

		// Entry into each shutdown is an event
		ev = '0;
		ev[EV_TSD] = st_nxt.thermal_sd & ~st_r.thermal_sd;
		ev[EV_UVLO] = st_nxt.uvlo & ~st_r.uvlo;
		ev[EV_OC_A] = (st_r.oc_st == OC_RUN) & trip[0];
		ev[EV_OC_B] = (st_r.oc_st == OC_RUN) & trip[1];

		// Live status word
		status = '0;
		status[ST_TSD] = st_r.thermal_sd;
		status[ST_UVLO] = st_r.uvlo;
		status[ST_OC] = (st_r.oc_st == OC_HOLD);
		status[ST_SINK_A] = st_r.sink[0];
		status[ST_SINK_B] = st_r.sink[1];
		status[ST_IN_A] = in_a_f;
		status[ST_IN_B] = in_b_f;

		// Answer in the first access cycle; data is latched at setup
		st_nxt.pready = setup;
		if (setup) begin
			st_nxt.prdata = read_word(paddr, status, st_r.int_stat, st_r.int_mask);
			st_nxt.pslverr = !mapped(paddr);
		end

		// Writes land on the completing edge only
		clr = '0;
		if (acc && pwrite && mapped(paddr)) begin
			case (paddr)
				REG_INT_STAT: clr = pwdata[EV_W-1:0];
				REG_INT_MASK: st_nxt.int_mask = pwdata[EV_W-1:0];
				default: clr = '0;
			endcase
		end

		// Write-one-to-clear; a new event in the same cycle wins
		st_nxt.int_stat = (st_r.int_stat & ~clr) | ev;
		st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '0;
			st_r.uvlo <= UVLO_RST;
			st_r.thermal_sd <= TSD_RST;
			st_r.oc_st <= OC_RUN;
			st_r.int_stat <= INT_STAT_RST;
			st_r.int_mask <= INT_MASK_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Every output straight from the state register
	assign sink_out_a = st_r.sink[0];
	assign sink_out_b = st_r.sink[1];
	assign fault_flag_o = st_r.flag_o;
	assign fault_flag_oe = st_r.flag_oe;
	assign irq = st_r.irq;
	assign prdata = st_r.prdata;
	assign pready = st_r.pready;
	assign pslverr = st_r.pslverr;

	// Checks on the protection behaviour
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_sink_follow:
	assert property ((in_a_f && !blocked) ##1 (in_a_f && !blocked) |-> ##1 sink_out_a)
		else $error("channel a not on with input high and no fault");

	a_sink_indep:
	assert property ((in_b_f && !in_a_f && !blocked) |=> (sink_out_b && !sink_out_a))
		else $error("channel b not independent of channel a");

	a_flag_idle:
	assert property ((!therm_f && !st_r.thermal_sd) |=> !fault_flag_oe && !fault_flag_o)
		else $error("fault flag driven in normal operation");

	a_flag_tsd:
	assert property ((tsd_t.done && therm_f) |=> fault_flag_oe && !fault_flag_o)
		else $error("fault flag not pulled low in thermal shutdown");

	a_flag_release:
	assert property ($fell(therm_f) |=> !fault_flag_oe)
		else $error("fault flag not released after thermal clear");

	a_tsd_off:
	assert property (fault_flag_oe |-> !sink_out_a && !sink_out_b)
		else $error("sink on during thermal shutdown");

	a_tsd_masked:
	assert property ((!st_r.thermal_sd && st_r.therm_cnt < TSD_MASK_CYCLES) |=> !st_r.thermal_sd)
		else $error("thermal shutdown taken without mask");

	a_tsd_window:
	assert property ($rose(st_r.thermal_sd) |-> $past(st_r.therm_cnt) == TSD_MASK_CYCLES)
		else $error("thermal mask length wrong");

	a_tsd_resume:
	assert property ((st_r.thermal_sd && !therm_f) |=> !st_r.thermal_sd)
		else $error("no automatic return after thermal clear");

	a_uvlo_off:
	assert property (low_f |=> !sink_out_a && !sink_out_b && st_r.uvlo)
		else $error("sink on during undervoltage");

	a_uvlo_hold:
	assert property ((st_r.uvlo && !ok_f) |=> st_r.uvlo)
		else $error("undervoltage lockout released early");

	a_oc_trip:
	assert property ((|trip && st_r.oc_st == OC_RUN) |=> !sink_out_a && !sink_out_b)
		else $error("sink on after overcurrent trip");

	a_oc_blank:
	assert property ((st_r.blk_cnt < OC_BLANK_CYCLES) |-> !blk_t[0].done)
		else $error("overcurrent accepted inside blanking");

	a_oc_blank_len:
	assert property ((blk_t[0].run && st_r.blk_cnt == OC_BLANK_CYCLES - 1) |=> blk_t[0].done)
		else $error("overcurrent blanking length wrong");

	a_oc_hold:
	assert property ($rose(st_r.oc_st == OC_HOLD) |-> (!sink_out_a && !sink_out_b) [*8])
		else $error("sink on during overcurrent off time");

	a_oc_recover:
	assert property (off_t.done |=> st_r.oc_st == OC_RUN)
		else $error("no recovery after overcurrent off time");

	a_flag_only_tsd:
	assert property ((!therm_f && (st_r.uvlo || st_r.oc_st == OC_HOLD)) |=> !fault_flag_oe)
		else $error("fault flag set by a non-thermal fault");

	a_irq_level:
	assert property ((st_r.int_stat & st_r.int_mask) == '0 |-> !irq)
		else $error("interrupt high with nothing pending");

endmodule

// ### test/host_ctrl_model.sv
// Host controller model that drives the two control inputs
module host_ctrl_model (
	input wire logic pclk,
	output logic ctrl_in_a,
	output logic ctrl_in_b
);
	timeunit 1ns;
	timeprecision 1ns;

	// Both inputs low from time zero
	initial begin
		ctrl_in_a = 1'b0;
		ctrl_in_b = 1'b0;
	end

	// New levels just after an edge, then held for at least 500 ns
	task automatic set_in(input logic a, input logic b);
		@(posedge pclk);
		ctrl_in_a <= a;
		ctrl_in_b <= b;
		repeat (5) @(posedge pclk);
	endtask
endmodule

// ### test/sink_guard_tb_top.sv
// Self-checking testbench of the sink driver protection logic
module sink_guard_tb_top import guard_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;

	// Shortened counts so the run stays brief
	localparam int THERMAL_TRIP = 6;
	localparam int BLK = 5;
	localparam int OFF = 20;

	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic therm = 1'b0;
	logic oc_a = 1'b0;
	logic oc_b = 1'b0;
	logic sup_low = 1'b0;
	logic sup_ok = 1'b1;
	wire logic [31:0] prdata;
	wire logic pready;
	wire logic pslverr;
	wire logic ctrl_in_a;
	wire logic ctrl_in_b;
	wire logic sink_out_a;
	wire logic sink_out_b;
	wire logic fault_flag_o;
	wire logic fault_flag_oe;
	wire logic irq;
	logic [31:0] rdv;
	logic erv;
	int errors = 0;
	int cmp_count = 0;

	// Open-drain flag pin with its external pull-up
	wire logic fault_pin = fault_flag_oe ? fault_flag_o : 1'b1;

	always #50 pclk = ~pclk;

	host_ctrl_model host_ctrl_model_inst (
		.pclk(pclk),
		.ctrl_in_a(ctrl_in_a),
		.ctrl_in_b(ctrl_in_b)
	);

	sink_guard #(
		.TSD_MASK_CYCLES(THERMAL_TRIP),
		.OC_BLANK_CYCLES(BLK),
		.OC_OFF_CYCLES(OFF)
	) sink_guard_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ctrl_in_a(ctrl_in_a),
		.ctrl_in_b(ctrl_in_b), .thermal_trip(therm), .overcurrent_trip_a(oc_a),
		.overcurrent_trip_b(oc_b), .motor_supply_low(sup_low),
		.motor_supply_ok(sup_ok), .sink_out_a(sink_out_a), .sink_out_b(sink_out_b),
		.fault_flag_o(fault_flag_o), .fault_flag_oe(fault_flag_oe), .irq(irq)
	);

	// Compare one value and count it
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// One APB transfer: setup, then access until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		logic seen;
		n = 0;
		seen = 1'b0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Look at the answer while it stands, then pass the edge that samples it
		while (!seen && n < 50) begin
			@(negedge pclk);
			n++;
			seen = (pready === 1'b1);
			rdv = prdata;
			erv = pslverr;
			@(posedge pclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
		chk("apb answer", 32'h0, seen ? 32'h0 : 32'h1);
	endtask

	// Both sinks and the flag pin against expectation, mid-cycle
	task automatic outs(input logic a, input logic b, input logic f);
		@(negedge pclk);
		chk("sink a", {31'h0, a}, {31'h0, sink_out_a});
		chk("sink b", {31'h0, b}, {31'h0, sink_out_b});
		chk("flag pin", {31'h0, f}, {31'h0, fault_pin});
		@(posedge pclk);
	endtask

	// Interrupt level against expectation, mid-cycle
	task automatic irq_is(input string n, input logic e);
		@(negedge pclk);
		chk(n, {31'h0, e}, {31'h0, irq});
		@(posedge pclk);
	endtask

	task automatic t_reset();
		outs(1'b0, 1'b0, 1'b1);
		apb(1'b0, REG_INT_MASK, 32'h0);
		chk("mask reset", 32'h0, rdv);
		apb(1'b1, REG_INT_STAT, 32'hF);
		irq_is("irq reset", 1'b0);
	endtask

	task automatic t_chan();
		for (int i = 0; i < 4; i++) begin
			host_ctrl_model_inst.set_in(i[0], i[1]);
			cyc(3);
			outs(i[0], i[1], 1'b1);
		end
	endtask

	task automatic t_therm();
		@(posedge pclk);
		therm <= 1'b1;
		cyc(THERMAL_TRIP - 2);
		therm <= 1'b0;
		cyc(10);
		outs(1'b1, 1'b1, 1'b1);
		therm <= 1'b1;
		cyc(THERMAL_TRIP + 3);
		outs(1'b1, 1'b1, 1'b1);
		cyc(5);
		outs(1'b0, 1'b0, 1'b0);
		therm <= 1'b0;
		cyc(8);
		outs(1'b1, 1'b1, 1'b1);
	endtask

	task automatic t_uvlo();
		@(posedge pclk);
		sup_low <= 1'b1;
		sup_ok <= 1'b0;
		cyc(8);
		outs(1'b0, 1'b0, 1'b1);
		sup_low <= 1'b0;
		cyc(8);
		outs(1'b0, 1'b0, 1'b1);
		sup_ok <= 1'b1;
		cyc(8);
		outs(1'b1, 1'b1, 1'b1);
	endtask

	task automatic t_oc();
		@(posedge pclk);
		oc_a <= 1'b1;
		cyc(BLK - 2);
		oc_a <= 1'b0;
		cyc(8);
		outs(1'b1, 1'b1, 1'b1);
		oc_a <= 1'b1;
		cyc(BLK + 8);
		outs(1'b0, 1'b0, 1'b1);
		oc_a <= 1'b0;
		cyc(10);
		outs(1'b0, 1'b0, 1'b1);
		cyc(20);
		outs(1'b1, 1'b1, 1'b1);
		oc_b <= 1'b1;
		cyc(BLK + 8);
		outs(1'b0, 1'b0, 1'b1);
		oc_b <= 1'b0;
		cyc(30);
		outs(1'b1, 1'b1, 1'b1);
	endtask

	// Sticky events, mask, clear, unmapped and read-only access
	task automatic t_regs();
		apb(1'b0, REG_INT_STAT, 32'h0);
		chk("events", 32'hF, rdv);
		irq_is("irq masked", 1'b0);
		apb(1'b1, REG_INT_MASK, 32'hF);
		apb(1'b0, REG_INT_MASK, 32'h0);
		chk("mask rw", 32'hF, rdv);
		irq_is("irq on", 1'b1);
		apb(1'b1, REG_INT_STAT, 32'h5);
		apb(1'b0, REG_INT_STAT, 32'h0);
		chk("w1c part", 32'hA, rdv);
		irq_is("irq held", 1'b1);
		apb(1'b1, REG_INT_STAT, 32'hA);
		irq_is("irq clear", 1'b0);
		apb(1'b1, REG_STATUS, 32'h0);
		chk("status write err", 32'h0, {31'h0, erv});
		apb(1'b0, REG_STATUS, 32'h0);
		chk("status", 32'h78, rdv);
		apb(1'b0, 8'h0C, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, erv});
		chk("unmapped data", 32'h0, rdv);
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		cyc(6);
		t_reset();
		t_chan();
		t_therm();
		t_uvlo();
		t_oc();
		t_regs();
		report_and_stop();
	end

	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		report_and_stop();
	end
endmodule
